// ### ccl_map.svh
// offsets, field positions, reset values and pipeline counts for the cascade logic
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH
// apb register byte offsets
`define CCL_CTRL_OFS 12'h000
`define CCL_STATUS_OFS 12'h004
`define CCL_ENTRY_SEL_OFS 12'h008
`define CCL_ENTRY_W0_OFS 12'h00c
`define CCL_ENTRY_W1_OFS 12'h010
`define CCL_ENTRY_W2_OFS 12'h014
// control register fields
`define CCL_CTRL_DEPTH_LSB 0
`define CCL_CTRL_DELAY_LSB 2
`define CCL_CTRL_DEFSRAM_BIT 5
`define CCL_CTRL_DEFFLAG_BIT 6
`define CCL_CTRL_ID_LSB 8
`define CCL_CTRL_RESET 32'h0000_0000
// entry select register fields
`define CCL_SEL_OCCVAL_BIT 8
`define CCL_SEL_OCCWR_BIT 9
// status register fields
`define CCL_STAT_FULL_BIT 0
`define CCL_STAT_CAP_BIT 1
`define CCL_STAT_NFA_LSB 8
`define CCL_STAT_NFAOK_BIT 14
// table depth codes and their search-to-sram latencies in clk cycles
`define CCL_DEPTH_ONE 2'b00
`define CCL_DEPTH_BLOCK 2'b01
`define CCL_DEPTH_MULTI 2'b10
`define CCL_LAT_ONE 4
`define CCL_LAT_BLOCK 5
`define CCL_LAT_MULTI 6
// cycle after the command at which the local match result is sampled
`define CCL_LOCAL_STAGE 4
// local array size, entry width and flag delay depth
`define CCL_ENTRIES 64
`define CCL_IDX_W 6
`define CCL_WORD_W 68
`define CCL_FLAG_DEPTH 8
`endif

// ### ccl_pkg.sv
// types shared by the cascade logic
package ccl_pkg;
  // opcode on the low two instruction bits
  typedef enum logic [1:0] {
    CCL_OP_NOP = 2'b00,
    CCL_OP_RSVD = 2'b01,
    CCL_OP_SEARCH = 2'b10,
    CCL_OP_LEARN = 2'b11
  } ccl_op_e;
  // instruction pair tracker
  typedef enum logic [0:0] {
    CCL_CMD_FIRST = 1'b0,
    CCL_CMD_SECOND = 1'b1
  } ccl_cmd_e;
  // what a pipeline slot carries
  typedef enum logic [1:0] {
    CCL_SLOT_NONE = 2'b00,
    CCL_SLOT_SEARCH = 2'b01,
    CCL_SLOT_LEARN = 2'b10
  } ccl_slot_e;
endpackage : ccl_pkg

// ### ccl_cascade.sv
// cascade search result arbitration, default bus driving and learn logic
//
// Operation
// - Local hit input bus counts as one condition, the OR of all seven bits.
// - Block hit input bus counts as one condition, the OR of all three bits.
// - Both local hit output bits always carry the same value.
// - All three block hit output bits always carry the same value.
// - Sram access follows the last command cycle by 4, 5 or 6 clocks per depth code.
// - Hit flag and valid lag the sram address by the hit delay code, 0 to 7.
// - Default sram driver drives address, chip and write enables when idle or missed.
// - Default flag driver drives hit flag and valid when idle or on global miss.
// - Entry bit 0 marks occupancy; all occupied raises the capacity output while the capacity input is high.
// - Last device's capacity output reports fullness of the whole table.
// - Only the first non-full device stores the comparand at next free location.
// - Learn writes one location in 68-bit tables, an even/odd pair in 136-bit.
// - Fullness is re-evaluated after every write or learn to the array.
// - Learn issues an sram write whose address holds the next free location.
// - Learn works only within one block and not for 272-bit tables.
// - Default sram driver raises sram output enable for two cycles per learn.
// - Learn is two pipelined cycles; next instruction after one idle cycle.
// - Learn sram write follows second learn cycle by 4 or 5 clocks; no learn at the 6-clock depth.
// - Devices arbitrate the sram bus; latency grows, issue rate stays.
// - Local result at cycle 4, block winner at 5, global winner at 6.
`include "ccl_map.svh"
module ccl_cascade
  import ccl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction bus
  input wire logic instruction_valid,
  input wire logic [8:0] instrBits,
  // comparand file and match core
  output logic [3:0] cmpPairIdx,
  input wire logic [67:0] cmpEvenWord,
  input wire logic [67:0] cmpOddWord,
  input wire logic matchHit,
  input wire logic [14:0] matchIndex,
  // cascade chain
  input wire logic [6:0] local_hit_in,
  output logic [1:0] local_hit_out,
  input wire logic [2:0] block_hit_in,
  output logic [2:0] block_hit_out,
  input wire logic capacity_in,
  output logic capacity_out,
  // shared sram bus, enables low while driving
  output logic [21:0] assoc_mem_addr,
  output logic memChipEn_n,
  output logic memWriteEn_n,
  output logic sramBusOe_n,
  output logic memOutEn_n,
  output logic memOutEnOe_n,
  // shared result flags
  output logic search_hit_flag,
  output logic search_result_valid,
  output logic flagBusOe_n
);

  // ---------------- configuration and array state ----------------
  logic [31:0] ctrl_ff;
  logic [`CCL_IDX_W-1:0] entrySel_ff;
  logic [`CCL_ENTRIES-1:0] occ_ff;
  logic [`CCL_WORD_W-1:0] dataArray [`CCL_ENTRIES];
  logic ownFull_ff;
  logic [1:0] depthCode;
  logic [2:0] hit_delay_code;
  logic default_sram_driver;
  logic default_flag_driver;
  logic [4:0] deviceId;
  logic apbWrite;
  logic apbRead;

  assign depthCode = ctrl_ff[`CCL_CTRL_DEPTH_LSB +: 2];
  assign hit_delay_code = ctrl_ff[`CCL_CTRL_DELAY_LSB +: 3];
  assign default_sram_driver = ctrl_ff[`CCL_CTRL_DEFSRAM_BIT];
  assign default_flag_driver = ctrl_ff[`CCL_CTRL_DEFFLAG_BIT];
  assign deviceId = ctrl_ff[`CCL_CTRL_ID_LSB +: 5];
  assign apbWrite = psel & penable & pready & pwrite;
  assign apbRead = psel & penable & ~pready & ~pwrite;

  // lowest free location; in pair mode only even slots with a free pair count
  function automatic logic [`CCL_IDX_W:0] nextFree(input logic [`CCL_ENTRIES-1:0] occ,
                                                    input logic pairMode);
    logic [`CCL_IDX_W:0] res;
    res = '0;
    for (int i = `CCL_ENTRIES - 1; i >= 0; i--) begin
      if (!pairMode && !occ[i]) begin
        res = {1'b1, i[`CCL_IDX_W-1:0]};
      end else if (pairMode && (i % 2 == 0) && !occ[i] && !occ[i+1]) begin
        res = {1'b1, i[`CCL_IDX_W-1:0]};
      end
    end
    return res;
  endfunction : nextFree

  // latency from the last command cycle to the sram cycle
  function automatic int latOf(input logic [1:0] code);
    case (code)
      `CCL_DEPTH_ONE: return `CCL_LAT_ONE;
      `CCL_DEPTH_BLOCK: return `CCL_LAT_BLOCK;
      default: return `CCL_LAT_MULTI;
    endcase
  endfunction : latOf

  // ---------------- instruction pair tracking ----------------
  ccl_cmd_e cmdState_ff;
  logic [1:0] firstOp_ff;
  logic [1:0] sramHi_ff;
  logic first272_ff;
  logic launchSearch;
  logic launchLearn;
  logic learnPair;
  logic [`CCL_IDX_W:0] freeSlot;
  logic isLearner;

  // a command completes on its second valid cycle; idle cycles restart pairing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdState_ff <= CCL_CMD_FIRST;
    end else begin
      case (cmdState_ff)
        CCL_CMD_FIRST: cmdState_ff <= instruction_valid ? CCL_CMD_SECOND : CCL_CMD_FIRST;
        CCL_CMD_SECOND: cmdState_ff <= CCL_CMD_FIRST;
        default: cmdState_ff <= CCL_CMD_FIRST;
      endcase
    end
  end

  // first-cycle fields: opcode, sram top bits, comparand pair index
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      firstOp_ff <= CCL_OP_NOP;
      sramHi_ff <= 2'b00;
      first272_ff <= 1'b0;
      cmpPairIdx <= 4'h0;
    end else if (instruction_valid && cmdState_ff == CCL_CMD_FIRST) begin
      firstOp_ff <= instrBits[1:0];
      sramHi_ff <= instrBits[8:7];
      first272_ff <= instrBits[2];
      cmpPairIdx <= instrBits[5:2];
    end
  end

  // a 272-bit search launches on its c/d pair only, whose first cycle has bit 2 low
  assign launchSearch = instruction_valid && cmdState_ff == CCL_CMD_SECOND
                        && firstOp_ff == CCL_OP_SEARCH && !first272_ff;
  assign launchLearn = instruction_valid && cmdState_ff == CCL_CMD_SECOND
                       && firstOp_ff == CCL_OP_LEARN && instrBits[1:0] == CCL_OP_LEARN
                       && depthCode != `CCL_DEPTH_MULTI;
  assign learnPair = instrBits[6];
  assign freeSlot = nextFree(occ_ff, learnPair);
  // first non-full device: everything upstream full, this one has room
  assign isLearner = launchLearn && capacity_in && !ownFull_ff && freeSlot[`CCL_IDX_W];

  // ---------------- data array and occupancy ----------------
  // learn stores the comparand words, bit 0 forced to one to mark occupancy
  always_ff @(posedge clk) begin
    if (isLearner) begin
      dataArray[freeSlot[`CCL_IDX_W-1:0]] <= {cmpEvenWord[67:1], 1'b1};
      if (learnPair) begin
        dataArray[freeSlot[`CCL_IDX_W-1:0] + 1'b1] <= {cmpOddWord[67:1], 1'b1};
      end
    end
  end

  // occupancy mirror of bit 0; software may also set or clear single entries
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      occ_ff <= '0;
    end else begin
      if (apbWrite && paddr == `CCL_ENTRY_SEL_OFS && pwdata[`CCL_SEL_OCCWR_BIT]) begin
        occ_ff[pwdata[`CCL_IDX_W-1:0]] <= pwdata[`CCL_SEL_OCCVAL_BIT];
      end
      if (isLearner) begin
        occ_ff[freeSlot[`CCL_IDX_W-1:0]] <= 1'b1;
        if (learnPair) begin
          occ_ff[freeSlot[`CCL_IDX_W-1:0] + 1'b1] <= 1'b1;
        end
      end
    end
  end

  // fullness follows the array one cycle after any write or learn
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ownFull_ff <= 1'b0;
      capacity_out <= 1'b0;
    end else begin
      ownFull_ff <= &occ_ff;
      capacity_out <= ownFull_ff & capacity_in;
    end
  end

  // ---------------- result pipeline ----------------
  // slot k holds a command k edges after its launch edge
  ccl_slot_e slotKind [6];
  logic [1:0] slotHi [6];
  logic [14:0] slotIdx [6];
  logic slotLearner [6];
  logic hit4_ff;
  logic blockWin5_ff;
  logic blockAny5_ff;
  logic localAny;
  logic blockAny;

  assign localAny = |local_hit_in;
  assign blockAny = |block_hit_in;

  // launch slot; a learn carries the free location as its sram index
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slotKind[0] <= CCL_SLOT_NONE;
      slotHi[0] <= 2'b00;
      slotIdx[0] <= 15'h0000;
      slotLearner[0] <= 1'b0;
    end else begin
      slotKind[0] <= launchSearch ? CCL_SLOT_SEARCH
                     : (launchLearn ? CCL_SLOT_LEARN : CCL_SLOT_NONE);
      slotHi[0] <= sramHi_ff;
      slotIdx[0] <= {{(15 - `CCL_IDX_W){1'b0}}, freeSlot[`CCL_IDX_W-1:0]};
      slotLearner[0] <= isLearner;
    end
  end

  // later slots shift; for a search the match index replaces the slot index at the local stage
  for (genvar k = 1; k < 6; k++) begin : g_slot
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        slotKind[k] <= CCL_SLOT_NONE;
        slotHi[k] <= 2'b00;
        slotIdx[k] <= 15'h0000;
        slotLearner[k] <= 1'b0;
      end else begin
        slotKind[k] <= slotKind[k-1];
        slotHi[k] <= slotHi[k-1];
        slotLearner[k] <= slotLearner[k-1];
        if (k == `CCL_LOCAL_STAGE && slotKind[k-1] == CCL_SLOT_SEARCH) begin
          slotIdx[k] <= matchIndex;
        end else begin
          slotIdx[k] <= slotIdx[k-1];
        end
      end
    end
  end

  // local result at edge 4, block winner at edge 5; hit outputs are replicated
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hit4_ff <= 1'b0;
      blockWin5_ff <= 1'b0;
      blockAny5_ff <= 1'b0;
      local_hit_out <= 2'b00;
      block_hit_out <= 3'b000;
    end else begin
      hit4_ff <= slotKind[3] == CCL_SLOT_SEARCH && matchHit;
      local_hit_out <= {2{slotKind[3] == CCL_SLOT_SEARCH && matchHit}};
      blockWin5_ff <= hit4_ff && !localAny;
      blockAny5_ff <= hit4_ff || localAny;
      block_hit_out <= {3{hit4_ff || localAny}};
    end
  end

  // ---------------- winner selection at the sram cycle ----------------
  int lat;
  logic srcSearch;
  logic srcLearner;
  logic srcLearn;
  logic preLearn;
  logic winNow;
  logic anyHitNow;
  logic [1:0] srcHi;
  logic [14:0] srcIdx;

  // the sram cycle is registered from slot lat-1, so the pins change at edge lat
  always_comb begin
    lat = latOf(depthCode);
    srcSearch = slotKind[lat-1] == CCL_SLOT_SEARCH;
    srcLearn = slotKind[lat-1] == CCL_SLOT_LEARN;
    srcLearner = srcLearn && slotLearner[lat-1];
    preLearn = slotKind[lat-2] == CCL_SLOT_LEARN;
    srcHi = slotHi[lat-1];
    // only a search takes the live match index; a learn keeps its free location
    srcIdx = (lat == `CCL_LAT_ONE && srcSearch) ? matchIndex : slotIdx[lat-1];
    case (depthCode)
      `CCL_DEPTH_ONE: begin
        winNow = srcSearch && matchHit;
        anyHitNow = winNow;
      end
      `CCL_DEPTH_BLOCK: begin
        winNow = srcSearch && hit4_ff && !localAny;
        anyHitNow = srcSearch && (hit4_ff || localAny);
      end
      default: begin
        winNow = srcSearch && blockWin5_ff && !blockAny;
        anyHitNow = srcSearch && (blockAny5_ff || blockAny);
      end
    endcase
  end

  // sram bus: winner or learner drives, else the default driver, else released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      assoc_mem_addr <= 22'h000000;
      memChipEn_n <= 1'b1;
      memWriteEn_n <= 1'b1;
      sramBusOe_n <= 1'b1;
    end else if (winNow || srcLearner) begin
      assoc_mem_addr <= {srcHi, deviceId, srcIdx};
      memChipEn_n <= 1'b0;
      memWriteEn_n <= ~srcLearner;
      sramBusOe_n <= 1'b0;
    end else if (default_sram_driver && !anyHitNow && !srcLearn) begin
      // idle value keeps the shared bus from floating without pull resistors
      assoc_mem_addr <= {srcHi, deviceId, 15'h0000};
      memChipEn_n <= 1'b1;
      memWriteEn_n <= 1'b1;
      sramBusOe_n <= 1'b0;
    end else begin
      assoc_mem_addr <= 22'h000000;
      memChipEn_n <= 1'b1;
      memWriteEn_n <= 1'b1;
      sramBusOe_n <= 1'b1;
    end
  end

  // sram output enable, owned by the default driver: high for the learn write and the cycle before
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memOutEn_n <= 1'b0;
      memOutEnOe_n <= 1'b1;
    end else begin
      memOutEn_n <= default_sram_driver && (srcLearn || preLearn);
      memOutEnOe_n <= ~default_sram_driver;
    end
  end

  // ---------------- delayed result flags ----------------
  logic [2:0] flagNow;
  logic [2:0] flagPipe [`CCL_FLAG_DEPTH];

  // {drive, hit, valid}; the default flag driver covers idle cycles and global misses
  always_comb begin
    if (winNow) begin
      flagNow = 3'b111;
    end else if (default_flag_driver && !anyHitNow) begin
      flagNow = {1'b1, 1'b0, srcSearch};
    end else begin
      flagNow = 3'b000;
    end
  end

  // flag delay line; stage 0 lines up with the sram address
  for (genvar k = 0; k < `CCL_FLAG_DEPTH; k++) begin : g_flag
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        flagPipe[k] <= 3'b000;
      end else if (k == 0) begin
        flagPipe[k] <= flagNow;
      end else begin
        flagPipe[k] <= flagPipe[k-1];
      end
    end
  end

  // tap named by the delay code; code zero bypasses the delay line
  logic [2:0] flagTap;
  assign flagTap = (hit_delay_code == 3'b000) ? flagNow
                   : flagPipe[hit_delay_code - 3'd1];

  // output flops, so the shared flag pins never glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      search_hit_flag <= 1'b0;
      search_result_valid <= 1'b0;
      flagBusOe_n <= 1'b1;
    end else begin
      search_hit_flag <= flagTap[1];
      search_result_valid <= flagTap[0];
      flagBusOe_n <= ~flagTap[2];
    end
  end

  // ---------------- apb slave ----------------
  // one wait state: pready rises in the second access cycle, so reads are registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (paddr > `CCL_ENTRY_W2_OFS || paddr[1:0] != 2'b00);
      if (apbRead) begin
        case (paddr)
          `CCL_CTRL_OFS: prdata <= ctrl_ff;
          `CCL_STATUS_OFS: prdata <= {17'h00000, freeSlot[`CCL_IDX_W],
                                      freeSlot[`CCL_IDX_W-1:0],
                                      6'h00, capacity_out, ownFull_ff};
          `CCL_ENTRY_SEL_OFS: prdata <= {26'h0000000, entrySel_ff};
          `CCL_ENTRY_W0_OFS: prdata <= dataArray[entrySel_ff][31:0];
          `CCL_ENTRY_W1_OFS: prdata <= dataArray[entrySel_ff][63:32];
          `CCL_ENTRY_W2_OFS: prdata <= {28'h0000000, dataArray[entrySel_ff][67:64]};
          default: prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // writable registers take effect at the completing edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= `CCL_CTRL_RESET;
      entrySel_ff <= '0;
    end else if (apbWrite) begin
      if (paddr == `CCL_CTRL_OFS) begin
        ctrl_ff <= pwdata & 32'h0000_1f7f;
      end
      if (paddr == `CCL_ENTRY_SEL_OFS) begin
        entrySel_ff <= pwdata[`CCL_IDX_W-1:0];
      end
    end
  end

endmodule : ccl_cascade

// ### ccl_cascade_sva.sv
// assertion checker for the cascade learn and bus drive block
`include "ccl_map.svh"
module ccl_cascade_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instruction_valid,
  input wire logic [8:0] instrBits,
  input wire logic [1:0] local_hit_out,
  input wire logic [2:0] block_hit_out,
  input wire logic capacity_in,
  input wire logic capacity_out,
  input wire logic memChipEn_n,
  input wire logic memWriteEn_n,
  input wire logic sramBusOe_n,
  input wire logic memOutEn_n,
  input wire logic memOutEnOe_n,
  input wire logic search_hit_flag,
  input wire logic search_result_valid,
  input wire logic flagBusOe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] ctrlSh_ff;
  logic ph_ff;
  logic [1:0] op1_ff;
  logic [4:0] idle_ff;
  logic ctrlWr, learnGo, sramRd, idle;
  assign ctrlWr = psel && penable && pready && pwrite && !pslverr && paddr == `CCL_CTRL_OFS;
  // shadow of the control word, so latency and driver bits are known here
  always_ff @(posedge clk) begin
    if (!rst_n) ctrlSh_ff <= `CCL_CTRL_RESET;
    else if (ctrlWr) ctrlSh_ff <= pwdata;
  end
  // pairs command cycles; an idle cycle restarts the pairing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_ff <= 1'b0;
      op1_ff <= 2'h0;
    end else begin
      ph_ff <= instruction_valid && !ph_ff;
      op1_ff <= instrBits[1:0];
    end
  end
  // quiet time; 16 cycles outlasts the longest pipeline plus flag delay
  always_ff @(posedge clk) begin
    if (!rst_n || instruction_valid || ctrlWr) idle_ff <= 5'h00;
    else if (idle_ff != 5'h1f) idle_ff <= idle_ff + 5'h01;
  end
  assign idle = idle_ff >= 5'h10;
  assign learnGo = instruction_valid && ph_ff && instrBits[1:0] == 2'h3 && op1_ff == 2'h3
    && ctrlSh_ff[1:0] != 2'h2;
  assign sramRd = !sramBusOe_n && !memChipEn_n && memWriteEn_n;
  AST_LHO_SAME: assert property (local_hit_out[0] == local_hit_out[1])
    else $error("local hit output bits differ");
  AST_BHO_SAME: assert property (block_hit_out == {3{block_hit_out[0]}})
    else $error("block hit output bits differ");
  AST_LEARN_L4: assert property (learnGo && ctrlSh_ff[1:0] == 2'h0 && ctrlSh_ff[5]
    && capacity_in && !capacity_out |-> ##5 (!sramBusOe_n && !memChipEn_n && !memWriteEn_n))
    else $error("learn write missing four cycles after launch");
  AST_LEARN_L5: assert property (learnGo && ctrlSh_ff[1:0] == 2'h1 && ctrlSh_ff[5]
    && capacity_in && !capacity_out |-> ##6 (!sramBusOe_n && !memChipEn_n && !memWriteEn_n))
    else $error("learn write missing five cycles after launch");
  AST_OE_TWO: assert property (learnGo && ctrlSh_ff[5] && ctrlSh_ff[1:0] == 2'h0 |->
    ##4 (memOutEn_n && !memOutEnOe_n) [*2] ##1 !memOutEn_n)
    else $error("sram output enable not high for exactly two cycles");
  AST_FLAG_D7: assert property (sramRd && ctrlSh_ff[4:2] == 3'h7 |->
    ##7 (search_hit_flag && search_result_valid && !flagBusOe_n))
    else $error("hit flags not seven cycles after sram address");
  AST_FLOAT: assert property (idle && !ctrlSh_ff[5] && !ctrlSh_ff[6] |->
    sramBusOe_n && flagBusOe_n && memOutEnOe_n)
    else $error("non-default device drives a shared pin");
  AST_DEF_SRAM: assert property (idle && ctrlSh_ff[5] |->
    !sramBusOe_n && memChipEn_n && memWriteEn_n)
    else $error("default sram driver not idling the bus");
  AST_DEF_FLAG: assert property (idle && ctrlSh_ff[6] |->
    !flagBusOe_n && !search_hit_flag && !search_result_valid)
    else $error("default flag driver not idling the flags");
  AST_CAP: assert property (!capacity_in |=> !capacity_out)
    else $error("capacity output high while upstream not full");
  cover property (learnGo);
  cover property (sramRd);
  cover property (capacity_out);
endmodule : ccl_cascade_chk
bind ccl_cascade ccl_cascade_chk u_chk (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .instruction_valid, .instrBits, .local_hit_out, .block_hit_out, .capacity_in,
  .capacity_out, .memChipEn_n, .memWriteEn_n, .sramBusOe_n, .memOutEn_n, .memOutEnOe_n,
  .search_hit_flag, .search_result_valid, .flagBusOe_n
);

// ### ccl_host_bfm.sv
// host model issuing two-cycle commands on the instruction bus
module ccl_host_bfm (
  input wire logic clk,
  output logic instruction_valid,
  output logic [8:0] instrBits
);
  timeunit 1ns;
  timeprecision 1ps;
  // released bus shows a pattern, not a stale command
  initial begin
    instruction_valid = 1'b0;
    instrBits = 9'h155;
  end
  // one command pair followed by the mandatory idle cycle
  task automatic cmd(input logic [8:0] a, input logic [8:0] b);
    @(posedge clk);
    instruction_valid <= 1'b1;
    instrBits <= a;
    @(posedge clk);
    instrBits <= b;
    @(posedge clk);
    instruction_valid <= 1'b0;
    instrBits <= ~b;
  endtask : cmd
endmodule : ccl_host_bfm

// ### tb_top.sv
// self-checking testbench for the cascade learn and bus drive block
`include "ccl_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic instruction_valid, matchHit, capacity_in, capacity_out;
  logic [8:0] instrBits;
  logic [3:0] cmpPairIdx;
  logic [67:0] cmpEvenWord, cmpOddWord;
  logic [14:0] matchIndex;
  logic [6:0] local_hit_in;
  logic [1:0] local_hit_out;
  logic [2:0] block_hit_in, block_hit_out;
  logic [21:0] assoc_mem_addr;
  logic memChipEn_n, memWriteEn_n, sramBusOe_n, memOutEn_n, memOutEnOe_n;
  logic search_hit_flag, search_result_valid, flagBusOe_n;
  int failures, comparisons;
  // search rows: depth, flag delay, upstream hits, expected win
  localparam logic [1:0] DP [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  localparam logic [2:0] DL [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7};
  localparam logic [6:0] LH [6] = '{7'h00, 7'h00, 7'h40, 7'h00, 7'h00, 7'h00};
  localparam logic [2:0] BH [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0};
  localparam logic WN [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  ccl_cascade u_dut (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .instruction_valid, .instrBits, .cmpPairIdx, .cmpEvenWord, .cmpOddWord, .matchHit,
    .matchIndex, .local_hit_in, .local_hit_out, .block_hit_in, .block_hit_out,
    .capacity_in, .capacity_out, .assoc_mem_addr, .memChipEn_n, .memWriteEn_n,
    .sramBusOe_n, .memOutEn_n, .memOutEnOe_n, .search_hit_flag, .search_result_valid,
    .flagBusOe_n
  );
  ccl_host_bfm u_host (.clk, .instruction_valid, .instrBits);
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far beyond the fewer than a thousand cycles the run needs
  initial begin
    #2ms;
    failures++;
    results();
  end
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : at
  function automatic logic [31:0] mk(input logic [1:0] d, input logic [2:0] dl, input logic s);
    return {19'h0, 5'h0b, 1'b0, s, s, dl, d};
  endfunction : mk
  // marks occupancy of a run of entries
  task automatic occ(input int lo, input int hi, input logic v);
    for (int i = lo; i <= hi; i++) apb(1'b1, `CCL_ENTRY_SEL_OFS, {22'h0, 1'b1, v, 2'h0, i[5:0]});
  endtask : occ
  // learn from pair 3, checking enable, write strobe and address at latency l
  task automatic lrn(input logic [8:0] b, input logic [14:0] na, input int l);
    u_host.cmd(9'h10f, b);
    at(0);
    chk("pair index", 4'h3, cmpPairIdx);
    at(l - 1);
    chk("oe before write", 1'b1, memOutEn_n);
    at(1);
    chk("learn write", 3'h0, {memChipEn_n, memWriteEn_n, sramBusOe_n});
    chk("learn addr", {2'h2, 5'h0b, na}, assoc_mem_addr);
  endtask : lrn
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    matchHit = 1'b1;
    matchIndex = 15'h1234;
    cmpEvenWord = 68'h0_1234_5678_9abc_def1; // top bits 00 tag an x68 entry
    cmpOddWord = 68'h8_7654_3210_fedc_ba99;
    local_hit_in = 7'h00;
    block_hit_in = 3'h0;
    capacity_in = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `CCL_CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, `CCL_CTRL_OFS, mk(DP[k], DL[k], 1'b0));
      local_hit_in <= LH[k];
      block_hit_in <= BH[k];
      u_host.cmd(9'h102, 9'h102);
      at(4 + DP[k]);
      chk("sram oe", !WN[k], sramBusOe_n);
      if (WN[k]) chk("sram addr", {2'h2, 5'h0b, 15'h1234}, assoc_mem_addr);
      if (DP[k] == 2'h0) chk("local hit out", 2'h3, local_hit_out);
      if (DP[k] == 2'h1) chk("block hit out", 3'h7, block_hit_out);
      at(DL[k]);
      chk("flag oe", !WN[k], flagBusOe_n);
      if (WN[k]) chk("hit flags", 2'h3, {search_hit_flag, search_result_valid});
    end
    at(16);
    chk("floating", 2'h3, {sramBusOe_n, flagBusOe_n});
    apb(1'b1, `CCL_CTRL_OFS, mk(2'h0, 3'h0, 1'b1));
    occ(0, 63, 1'b0);
    occ(0, 1, 1'b1);
    lrn(9'h10f, 15'h2, 4);
    lrn(9'h14f, 15'h4, 4);
    apb(1'b0, `CCL_STATUS_OFS, 32'h0);
    chk("next free", 7'h43, rd[14:8]);
    at(16);
    chk("default sram", 3'h3, {sramBusOe_n, memChipEn_n, memWriteEn_n});
    chk("default flags", 3'h0, {flagBusOe_n, search_hit_flag, search_result_valid});
    matchHit <= 1'b0;
    u_host.cmd(9'h102, 9'h102);
    at(4);
    chk("miss bus", 3'h3, {sramBusOe_n, memChipEn_n, memWriteEn_n});
    chk("miss flags", 3'h1, {flagBusOe_n, search_hit_flag, search_result_valid});
    occ(0, 63, 1'b1);
    at(3);
    chk("capacity out", 1'b1, capacity_out);
    capacity_in <= 1'b0;
    at(3);
    chk("capacity chained", 1'b0, capacity_out);
    capacity_in <= 1'b1;
    occ(0, 1, 1'b0);
    apb(1'b0, `CCL_STATUS_OFS, 32'h0);
    chk("full cleared", 7'h40, {rd[14:8]} | {6'h0, rd[0]});
    apb(1'b1, `CCL_CTRL_OFS, mk(2'h2, 3'h0, 1'b1));
    u_host.cmd(9'h10f, 9'h10f);
    at(6);
    chk("no learn write", 1'b1, memWriteEn_n);
    apb(1'b1, `CCL_CTRL_OFS, mk(2'h1, 3'h0, 1'b1));
    lrn(9'h10f, 15'h0, 5);
    results();
  end
endmodule : tb_top
